// *** logic/irq_gen_defs.svh ***
// Constants for the host interrupt generator: field positions, reset values and timing.
`ifndef IRQ_GEN_DEFS_SVH
`define IRQ_GEN_DEFS_SVH

`define CLK_PERIOD_NS 40
`define EVENT_COUNT 16
`define DONE_BITS 32
`define CATEGORIES 3

`define MODE_GLOBAL_EN_BIT 0
`define MODE_TRIGGER_BIT 1
`define MODE_POLARITY_BIT 2
`define MODE_WIDTH 3
`define MODE_RST 3'h0

`define PULSE_LSB 0
`define PULSE_MSB 15
`define INTERVAL_LSB 24
`define INTERVAL_MSB 31
`define PULSE_CODE_RST 16'h0021
`define INTERVAL_CODE_RST 8'h00
`define PULSE_CODE_MAX 17'h0ffff

`define PULSE_MAX_NS 1000000
`define PULSE_MAX_CYC ((`PULSE_MAX_NS) / (`CLK_PERIOD_NS))
`define INTERVAL_UNIT_NS 1000
`define INTERVAL_UNIT_CYC (((`INTERVAL_UNIT_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

`define CAT_ISO 0
`define CAT_PERIODIC 1
`define CAT_ASYNC 2
`define EV_ISO_DONE_BIT 7
`define EV_PERIODIC_DONE_BIT 8
`define EV_ASYNC_DONE_BIT 9

`define TIMER_WIDTH 24
`define TIMEOUT_WIDTH 16

`endif

// *** logic/irq_gen_pkg.sv ***
// Types shared by the host interrupt generator.
package irq_gen_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_HOLDOFF
	} irq_state_t;
endpackage

// *** logic/done_mask_eval.sv ***
// Per-category AND/OR mask evaluation of a transfer_descriptor done map.
`timescale 1ns/1ps
module done_mask_eval #(
	parameter int DONE_BITS = 32
)(
	// Done map and masks
	input wire logic [DONE_BITS-1:0] done_map_in,
	input wire logic [DONE_BITS-1:0] and_mask_in,
	input wire logic [DONE_BITS-1:0] or_mask_in,
	// Request
	output logic hit_out
);
	logic [DONE_BITS-1:0] and_eff;
	logic or_hit;
	logic and_hit;

	// Any OR-selected done bit requests at once.
	assign or_hit = |(done_map_in & or_mask_in);
	// AND-selected bits not also OR-selected must all be done.
	assign and_eff = and_mask_in & ~or_mask_in;
	assign and_hit = (and_eff != '0) && ((done_map_in & and_eff) == and_eff);
	assign hit_out = or_hit | and_hit;
endmodule // done_mask_eval

// *** logic/host_irq_generator.sv ***
// Interrupt generator of the host controller: status flags, masks and the IRQ pin.
`timescale 1ns/1ps
`include "irq_gen_defs.svh"
module host_irq_generator #(
	parameter int EVENTS = `EVENT_COUNT,
	parameter int DONE_BITS = `DONE_BITS,
	parameter int PULSE_MAX_CYCLES = `PULSE_MAX_CYC,
	parameter int INTERVAL_UNIT_CYCLES = `INTERVAL_UNIT_CYC
)(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Hardware mode control
	input wire logic hw_mode_wr_in,
	input wire logic [`MODE_WIDTH-1:0] hw_mode_data_in,
	// Edge count control
	input wire logic edge_count_wr_in,
	input wire logic [31:0] edge_count_data_in,
	// Events and enables
	input wire logic [EVENTS-1:0] event_in,
	input wire logic [EVENTS-1:0] event_enable_mask_in,
	// Status flag clear
	input wire logic status_clear_wr_in,
	input wire logic [EVENTS-1:0] status_clear_data_in,
	// Done maps
	input wire logic [DONE_BITS-1:0] iso_done_map_in,
	input wire logic [DONE_BITS-1:0] periodic_done_map_in,
	input wire logic [DONE_BITS-1:0] async_done_map_in,
	// Masks
	input wire logic [DONE_BITS-1:0] iso_and_mask_in,
	input wire logic [DONE_BITS-1:0] iso_or_mask_in,
	input wire logic [DONE_BITS-1:0] periodic_and_mask_in,
	input wire logic [DONE_BITS-1:0] periodic_or_mask_in,
	input wire logic [DONE_BITS-1:0] async_and_mask_in,
	input wire logic [DONE_BITS-1:0] async_or_mask_in,
	// Async interval option
	input wire logic async_interval_en_in,
	input wire logic [`TIMEOUT_WIDTH-1:0] async_timeout_in,
	// Interrupt pin
	output logic irq_out,
	// Status
	output logic [EVENTS-1:0] event_status_flags_out,
	output logic [`MODE_WIDTH-1:0] hw_mode_out,
	output logic [31:0] edge_count_out,
	output irq_gen_pkg::irq_state_t irq_state_out,
	output logic [DONE_BITS-1:0] iso_done_map_out,
	output logic [DONE_BITS-1:0] periodic_done_map_out,
	output logic [DONE_BITS-1:0] async_done_map_out
);
	import irq_gen_pkg::*;

	localparam int TW = `TIMER_WIDTH;
	localparam int TOW = `TIMEOUT_WIDTH;

	logic [`MODE_WIDTH-1:0] mode_q;
	logic [15:0] pulse_code_q;
	logic [7:0] interval_code_q;
	logic global_en;
	logic edge_mode;
	logic pol_high;

	logic [EVENTS-1:0] flags_q;
	logic [EVENTS-1:0] flags_d;
	logic [EVENTS-1:0] set_vec;
	logic [EVENTS-1:0] clr_vec;

	logic [DONE_BITS-1:0] done_q [`CATEGORIES];
	logic [DONE_BITS-1:0] and_m [`CATEGORIES];
	logic [DONE_BITS-1:0] or_m [`CATEGORIES];
	logic [`CATEGORIES-1:0] hit;
	logic [`CATEGORIES-1:0] hit_prev_q;
	logic [`CATEGORIES-1:0] hit_rise;

	logic [TW-1:0] unit_cnt_q;
	logic unit_tick;
	logic [`TIMEOUT_WIDTH-1:0] timeout_cnt_q;
	logic async_pending_q;
	logic async_expire;

	irq_state_t state_q;
	logic [TW-1:0] cnt_q;
	logic cond;
	logic cond_prev_q;
	logic edge_pending_q;
	logic [47:0] pulse_prod;
	logic [TW-1:0] pulse_cycles;
	logic [TW-1:0] holdoff_cycles;
	logic active_d;

	// Configuration registers; reset gives disabled, level, active low.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			mode_q <= `MODE_RST;
		end else if (hw_mode_wr_in) begin
			mode_q <= hw_mode_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pulse_code_q <= `PULSE_CODE_RST;
			interval_code_q <= `INTERVAL_CODE_RST;
		end else if (edge_count_wr_in) begin
			pulse_code_q <= edge_count_data_in[`PULSE_MSB:`PULSE_LSB];
			interval_code_q <= edge_count_data_in[`INTERVAL_MSB:`INTERVAL_LSB];
		end
	end

	assign global_en = mode_q[`MODE_GLOBAL_EN_BIT];
	assign edge_mode = mode_q[`MODE_TRIGGER_BIT];
	assign pol_high = mode_q[`MODE_POLARITY_BIT];

	// The pulse code scales so that the full code gives the maximum width.
	assign pulse_prod = 48'(pulse_code_q) * 48'(PULSE_MAX_CYCLES) + 48'(`PULSE_CODE_MAX);
	always_comb begin
		pulse_cycles = pulse_prod[16+TW-1:16];
		if (pulse_cycles == '0) begin
			pulse_cycles = TW'(1);
		end
	end
	// A zero interval code gives no hold-off.
	assign holdoff_cycles = TW'(interval_code_q) * TW'(INTERVAL_UNIT_CYCLES);

	// Done maps are captured so they can be read back alongside the IRQ.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			done_q[`CAT_ISO] <= '0;
			done_q[`CAT_PERIODIC] <= '0;
			done_q[`CAT_ASYNC] <= '0;
		end else begin
			done_q[`CAT_ISO] <= iso_done_map_in;
			done_q[`CAT_PERIODIC] <= periodic_done_map_in;
			done_q[`CAT_ASYNC] <= async_done_map_in;
		end
	end

	assign and_m[`CAT_ISO] = iso_and_mask_in;
	assign and_m[`CAT_PERIODIC] = periodic_and_mask_in;
	assign and_m[`CAT_ASYNC] = async_and_mask_in;
	assign or_m[`CAT_ISO] = iso_or_mask_in;
	assign or_m[`CAT_PERIODIC] = periodic_or_mask_in;
	assign or_m[`CAT_ASYNC] = async_or_mask_in;

	// Each category is judged only against its own masks.
	generate
		for (genvar c = 0; c < `CATEGORIES; c++) begin : g_cat
			done_mask_eval #(
				.DONE_BITS(DONE_BITS)
			) u_eval (
				.done_map_in(done_q[c]),
				.and_mask_in(and_m[c]),
				.or_mask_in(or_m[c]),
				.hit_out(hit[c])
			);
		end
	endgenerate

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			hit_prev_q <= '0;
		end else begin
			hit_prev_q <= hit;
		end
	end
	assign hit_rise = hit & ~hit_prev_q;

	// Microsecond-unit tick used only by the async timeout; the hold-off counts clock cycles scaled by INTERVAL_UNIT_CYCLES.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			unit_cnt_q <= '0;
		end else if (unit_tick) begin
			unit_cnt_q <= '0;
		end else begin
			unit_cnt_q <= unit_cnt_q + TW'(1);
		end
	end
	assign unit_tick = (unit_cnt_q == TW'(INTERVAL_UNIT_CYCLES - 1));

	// Async completions wait for the timeout before flagging.
	always_ff @(posedge clk_in) begin
		if (rst_in || !async_interval_en_in) begin
			timeout_cnt_q <= '0;
		end else if (unit_tick) begin
			if (timeout_cnt_q >= async_timeout_in) begin
				timeout_cnt_q <= '0;
			end else begin
				timeout_cnt_q <= timeout_cnt_q + TOW'(1);
			end
		end
	end
	assign async_expire = async_interval_en_in && unit_tick && (timeout_cnt_q >= async_timeout_in);

	always_ff @(posedge clk_in) begin
		if (rst_in || !async_interval_en_in) begin
			async_pending_q <= 1'b0;
		end else if (hit_rise[`CAT_ASYNC]) begin
			async_pending_q <= 1'b1;
		end else if (async_expire) begin
			async_pending_q <= 1'b0;
		end
	end

	// Sources that set flags: raw events plus category requests.
	always_comb begin
		set_vec = event_in;
		set_vec[`EV_ISO_DONE_BIT] = event_in[`EV_ISO_DONE_BIT] | hit_rise[`CAT_ISO];
		set_vec[`EV_PERIODIC_DONE_BIT] = event_in[`EV_PERIODIC_DONE_BIT]
			| hit_rise[`CAT_PERIODIC];
		if (async_interval_en_in) begin
			set_vec[`EV_ASYNC_DONE_BIT] = event_in[`EV_ASYNC_DONE_BIT]
				| (async_expire & async_pending_q);
		end else begin
			set_vec[`EV_ASYNC_DONE_BIT] = event_in[`EV_ASYNC_DONE_BIT]
				| hit_rise[`CAT_ASYNC];
		end
	end

	// Flags are plain sticky bits, set regardless of enables; set beats clear.
	assign clr_vec = status_clear_wr_in ? status_clear_data_in : '0;
	assign flags_d = (flags_q & ~clr_vec) | set_vec;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Combined interrupt condition.
	assign cond = global_en && ((flags_q & event_enable_mask_in) != '0);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cond_prev_q <= 1'b0;
		end else begin
			cond_prev_q <= cond;
		end
	end

	// A rising condition is remembered, while the condition holds, until a pulse can start.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			edge_pending_q <= 1'b0;
		end else if (!cond) begin
			edge_pending_q <= 1'b0;
		end else if (state_q == ST_IDLE && edge_mode) begin
			edge_pending_q <= 1'b0;
		end else if (!cond_prev_q) begin
			edge_pending_q <= 1'b1;
		end
	end

	// Output sequencer: idle, asserted, then optional hold-off spacing.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (edge_mode && cond && (edge_pending_q || !cond_prev_q)) begin
						state_q <= ST_ACTIVE;
						cnt_q <= pulse_cycles - TW'(1);
					end else if (!edge_mode && cond) begin
						state_q <= ST_ACTIVE;
						cnt_q <= '0;
					end
				end
				ST_ACTIVE: begin
					if (edge_mode) begin
						// Clearing flags does not cut the pulse short.
						if (cnt_q == '0) begin
							state_q <= (holdoff_cycles == '0) ? ST_IDLE : ST_HOLDOFF;
							cnt_q <= holdoff_cycles - TW'(1);
						end else begin
							cnt_q <= cnt_q - TW'(1);
						end
					end else if (!cond) begin
						state_q <= (holdoff_cycles == '0) ? ST_IDLE : ST_HOLDOFF;
						cnt_q <= holdoff_cycles - TW'(1);
					end
				end
				ST_HOLDOFF: begin
					if (cnt_q == '0) begin
						state_q <= ST_IDLE;
					end else begin
						cnt_q <= cnt_q - TW'(1);
					end
				end
			endcase
		end
	end

	// Pin level follows the active state through the polarity select.
	always_comb begin
		active_d = 1'b0;
		unique case (state_q)
			ST_ACTIVE: active_d = edge_mode ? 1'b1 : cond;
			ST_IDLE: active_d = 1'b0;
			ST_HOLDOFF: active_d = 1'b0;
		endcase
	end

	// The whole block sits on the always-running clock, so suspend does not stop it.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			irq_out <= 1'b1;
		end else begin
			irq_out <= pol_high ? active_d : ~active_d;
		end
	end

	// Registered status views.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			event_status_flags_out <= '0;
			hw_mode_out <= `MODE_RST;
			edge_count_out <= {`INTERVAL_CODE_RST, 8'h00, `PULSE_CODE_RST};
			irq_state_out <= ST_IDLE;
			iso_done_map_out <= '0;
			periodic_done_map_out <= '0;
			async_done_map_out <= '0;
		end else begin
			event_status_flags_out <= flags_d;
			hw_mode_out <= mode_q;
			edge_count_out <= {interval_code_q, 8'h00, pulse_code_q};
			irq_state_out <= state_q;
			iso_done_map_out <= done_q[`CAT_ISO];
			periodic_done_map_out <= done_q[`CAT_PERIODIC];
			async_done_map_out <= done_q[`CAT_ASYNC];
		end
	end
endmodule // host_irq_generator

// *** test/host_irq_generator_monitor.sv ***
// Port checker of the host interrupt generator.
`timescale 1ns/1ps
module host_irq_generator_monitor
	import irq_gen_pkg::*;
#(
	parameter int PULSE_MAX_CYCLES = 200,
	parameter int INTERVAL_UNIT_CYCLES = 2
)(
	// Inputs
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [15:0] event_in,
	input wire logic [15:0] event_enable_mask_in,
	input wire logic status_clear_wr_in,
	input wire logic [15:0] status_clear_data_in,
	input wire logic [31:0] iso_done_map_in,
	input wire logic [31:0] iso_or_mask_in,
	input wire logic [31:0] periodic_done_map_in,
	input wire logic [31:0] periodic_and_mask_in,
	// Outputs
	input wire logic irq_out,
	input wire logic [15:0] event_status_flags_out,
	input wire logic [2:0] hw_mode_out,
	input wire logic [31:0] edge_count_out,
	input wire irq_gen_pkg::irq_state_t irq_state_out
);
	import irq_gen_pkg::*;
	irq_state_t prev_q;
	logic [15:0] run_q;
	logic [63:0] pulse_len;
	assign pulse_len = ((64'(edge_count_out[15:0]) * PULSE_MAX_CYCLES) + 64'hffff) >> 16;
	// Counts how many cycles the state has shown the same value.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prev_q <= ST_IDLE;
			run_q <= 16'h1;
		end else begin
			prev_q <= irq_state_out;
			run_q <= (irq_state_out == prev_q) ? run_q + 16'h1 : 16'h1;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_no_global;
		!hw_mode_out[0] && irq_state_out == ST_IDLE |=> irq_state_out == ST_IDLE;
	endproperty
	a_no_global: assert property (p_no_global) else $error("IRQ raised while disabled");
	property p_pin;
		$stable(hw_mode_out) |-> irq_out == ((irq_state_out == ST_ACTIVE && (hw_mode_out[1]
			|| (hw_mode_out[0] && ($past(event_status_flags_out)
			& $past(event_enable_mask_in)) != 16'h0))) ~^ hw_mode_out[2]);
	endproperty
	a_pin: assert property (p_pin) else $error("IRQ pin level wrong");
	property p_reset;
		$fell(rst_in) |-> hw_mode_out == 3'h0 && irq_out && edge_count_out == 32'h0000_0021;
	endproperty
	a_reset: assert property (p_reset) else $error("Reset defaults wrong");
	property p_set;
		|event_in |=> (event_status_flags_out & $past(event_in)) == $past(event_in);
	endproperty
	a_set: assert property (p_set) else $error("Event flag not set");
	property p_clear;
		status_clear_wr_in && event_in == 16'h0
		|=> (event_status_flags_out & $past(status_clear_data_in) & 16'hfc7f) == 16'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("Flag not cleared");
	property p_pulse;
		prev_q == ST_ACTIVE && irq_state_out != ST_ACTIVE && hw_mode_out[1]
		|-> 64'(run_q) == ((pulse_len == 64'h0) ? 64'h1 : pulse_len);
	endproperty
	a_pulse: assert property (p_pulse) else $error("Pulse length wrong");
	property p_hold_entry;
		prev_q == ST_ACTIVE && irq_state_out != ST_ACTIVE
		|-> (irq_state_out == ST_HOLDOFF) == (edge_count_out[31:24] != 8'h00);
	endproperty
	a_hold_entry: assert property (p_hold_entry) else $error("Hold-off entry wrong");
	property p_hold_len;
		prev_q == ST_HOLDOFF && irq_state_out != ST_HOLDOFF
		|-> 32'(run_q) == 32'(edge_count_out[31:24]) * INTERVAL_UNIT_CYCLES;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("Hold-off length wrong");
	property p_or;
		$rose(|(iso_done_map_in & iso_or_mask_in)) |-> ##[1:4] event_status_flags_out[7];
	endproperty
	a_or: assert property (p_or) else $error("OR mask request lost");
	property p_and;
		$rose(periodic_and_mask_in != 32'h0
			&& (periodic_done_map_in & periodic_and_mask_in) == periodic_and_mask_in)
		|-> ##[1:4] event_status_flags_out[8];
	endproperty
	a_and: assert property (p_and) else $error("AND mask request lost");
endmodule // host_irq_generator_monitor

bind host_irq_generator host_irq_generator_monitor #(.PULSE_MAX_CYCLES(PULSE_MAX_CYCLES),
	.INTERVAL_UNIT_CYCLES(INTERVAL_UNIT_CYCLES)) i_host_irq_generator_monitor (.clk_in, .rst_in,
	.event_in, .event_enable_mask_in, .status_clear_wr_in, .status_clear_data_in,
	.iso_done_map_in, .iso_or_mask_in,
	.periodic_done_map_in, .periodic_and_mask_in, .irq_out, .event_status_flags_out,
	.hw_mode_out, .edge_count_out, .irq_state_out);

// *** test/host_irq_input_model.sv ***
// Model of the processor interrupt input that watches the IRQ pin.
`timescale 1ns/1ps
module host_irq_input_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Pin and the polarity software chose
	input wire logic irq_in,
	input wire logic active_high_in,
	// Interrupts taken
	output logic [7:0] irq_count_out
);
	logic seen_q;
	// Counts each entry into the active level chosen to match the pin.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			seen_q <= 1'b0;
			irq_count_out <= 8'h0;
		end else begin
			seen_q <= (irq_in == active_high_in);
			if ((irq_in == active_high_in) && !seen_q) begin
				irq_count_out <= irq_count_out + 8'h1;
			end
		end
	end
endmodule // host_irq_input_model

// *** test/host_irq_generator_tb.sv ***
// Self-checking bench of the host interrupt generator.
`timescale 1ns/1ps
module host_irq_generator_tb;
	import irq_gen_pkg::*;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic mode_wr = 1'b0, count_wr = 1'b0, clr_wr = 1'b0, iv_en = 1'b0;
	logic [2:0] mode_d = 3'h0;
	logic [31:0] count_d = 32'h0;
	logic [15:0] ev = 16'h0, en = 16'h0, clr_d = 16'h0, tmo = 16'h0;
	logic [31:0] iso_d = 32'h0, per_d = 32'h0, as_d = 32'h0, iso_a = 32'h0, iso_o = 32'h0;
	logic [31:0] per_a = 32'h0, per_o = 32'h0, as_a = 32'h0, as_o = 32'h0, per_rb, iso_rb, as_rb;
	logic irq;
	logic [15:0] flags;
	logic [2:0] mode_rb;
	logic [31:0] count_rb;
	logic [7:0] host_cnt, base;
	irq_state_t st;
	logic [15:0] codes [3] = '{16'h0021, 16'h0800, 16'hffff};
	int widths [3] = '{1, 7, 200};
	int num_errors = 0, checked = 0, cyc = 0, n, hi = 0;
	host_irq_generator #(.PULSE_MAX_CYCLES(200), .INTERVAL_UNIT_CYCLES(2)) i_host_irq_generator (
		.clk_in(clk_in), .rst_in(rst_in), .hw_mode_wr_in(mode_wr), .hw_mode_data_in(mode_d),
		.edge_count_wr_in(count_wr), .edge_count_data_in(count_d), .event_in(ev),
		.event_enable_mask_in(en), .status_clear_wr_in(clr_wr), .status_clear_data_in(clr_d),
		.iso_done_map_in(iso_d), .periodic_done_map_in(per_d), .async_done_map_in(as_d),
		.iso_and_mask_in(iso_a), .iso_or_mask_in(iso_o), .periodic_and_mask_in(per_a),
		.periodic_or_mask_in(per_o), .async_and_mask_in(as_a), .async_or_mask_in(as_o),
		.async_interval_en_in(iv_en), .async_timeout_in(tmo), .irq_out(irq),
		.event_status_flags_out(flags), .hw_mode_out(mode_rb), .edge_count_out(count_rb),
		.irq_state_out(st), .iso_done_map_out(iso_rb), .periodic_done_map_out(per_rb),
		.async_done_map_out(as_rb));
	host_irq_input_model i_host_irq_input_model (.clk_in(clk_in), .rst_in(rst_in),
		.irq_in(irq), .active_high_in(mode_d[2]), .irq_count_out(host_cnt));
	always #20 clk_in = ~clk_in;
	// Counts the cycles in which the pin is high.
	always @(negedge clk_in) begin
		if (irq === 1'b1) begin
			hi++;
		end
	end
	task automatic summarize;
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(negedge clk_in);
	endtask
	// Strobes one write: 0 mode, 1 edge count, 2 flag clear, 3 event; then idles a cycle.
	task automatic put(input int w, input logic [31:0] d);
		if (w == 0) begin
			mode_d = d[2:0];
		end
		count_d = d;
		clr_d = d[15:0];
		mode_wr = (w == 0);
		count_wr = (w == 1);
		clr_wr = (w == 2);
		ev = (w == 3) ? d[15:0] : 16'h0;
		tick(1);
		{mode_wr, count_wr, clr_wr} = 3'h0;
		ev = 16'h0;
		tick(1);
	endtask
	task automatic wait_irq(input logic v, input int lim);
		n = 0;
		while (irq !== v && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		tick(1);
		check(mode_rb, 3'h0);
		check(count_rb, 32'h21);
		check(irq, 1'b1);
		check(st, ST_IDLE);
		$display("test reset done");
		put(3, 32'h1);
		put(0, 32'h1);
		tick(8);
		check(flags, 16'h1);
		check(irq, 1'b1);
		put(2, 32'h1);
		en = 16'h0007;
		put(0, 32'h0);
		put(3, 32'h2);
		tick(8);
		check(irq, 1'b1);
		put(0, 32'h1);
		wait_irq(1'b0, 10);
		check(irq, 1'b0);
		put(3, 32'h1);
		put(2, 32'h0);
		put(2, 32'h2);
		tick(8);
		check(flags, 16'h1);
		check(irq, 1'b0);
		put(2, 32'h1);
		wait_irq(1'b1, 10);
		check(irq, 1'b1);
		$display("test level done");
		put(0, 32'h7);
		foreach (codes[i]) begin
			put(1, {16'h0, codes[i]});
			base = host_cnt;
			n = hi;
			put(3, 32'h4);
			put(2, 32'h4);
			tick(210);
			check(hi - n, widths[i]);
			check(8'(host_cnt - base), 8'h1);
		end
		$display("test pulse done");
		put(1, 32'h0500_0800);
		base = host_cnt;
		put(3, 32'h1);
		wait_irq(1'b1, 10);
		put(2, 32'h1);
		wait_irq(1'b0, 20);
		put(3, 32'h2);
		tick(2);
		check(irq, 1'b0);
		put(3, 32'h4);
		check(flags, 16'h6);
		wait_irq(1'b1, 20);
		tick(1);
		check(8'(host_cnt - base), 8'h2);
		put(2, 32'hffff);
		$display("test spacing done");
		put(0, 32'h1);
		en = 16'h0380;
		iso_o = 32'h80;
		per_a = 32'h16;
		per_d = 32'h86;
		tick(6);
		check(flags, 16'h0);
		iso_d = 32'h80;
		tick(6);
		check(flags, 16'h80);
		per_d = 32'h96;
		tick(6);
		check(flags, 16'h180);
		check(per_rb, 32'h96);
		check(iso_rb, 32'h80);
		check(irq, 1'b0);
		as_o = 32'h1;
		iv_en = 1'b1;
		tmo = 16'd200;
		as_d = 32'h1;
		tick(6);
		check(flags[9], 1'b0);
		n = 0;
		while (flags[9] !== 1'b1 && n < 6000) begin
			tick(1);
			n++;
		end
		check(flags[9], 1'b1);
		check(as_rb, 32'h1);
		$display("test masks done");
		summarize();
	end
endmodule // host_irq_generator_tb
